// ---- hdl/ascs_step_config.sv ----
`timescale 1ns/1ps
// Operation
// (RULE_01) Bit 15 enables this step
// (RULE_02) Gain bits 14:13: x1, x2, x4, x4
// (RULE_03) Bit 4 picks ground or input 7
// (RULE_04) Codes 0-7 select external inputs 0-7
// (RULE_05) Codes 8+ internal, negative chosen automatically
// (RULE_06) Index 98h, resets to 0008h
// (RULE_07) Bits 12:5 read zero, ignore writes
module ascs_step_config (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // Avalon-MM slave
    input wire logic [9:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    // Step settings to the sequencer
    output logic stepEnable,
    output logic [1:0] stepGainSelect,
    output logic [2:0] stepGainFactor,
    output logic stepNegativeInputSelect,
    output logic [3:0] stepPositiveInputSelect,
    output logic stepPositiveInternal,
    output logic [2:0] stepExternalChannel,
    output logic [1:0] stepNegativeRoute
);
    logic [15:0] cfgWord;
    logic ack_q;
    logic [31:0] rdData_q;
    logic hit;
    logic req;
    logic doWrite;

    function automatic logic [2:0] gain_factor(input logic [1:0] code);
        unique case (code)
            ascs_pkg::ASCS_GAIN_X1: gain_factor = 3'h1;
            ascs_pkg::ASCS_GAIN_X2: gain_factor = 3'h2;
            default: gain_factor = 3'h4; // Both upper codes mean x4
        endcase
    endfunction : gain_factor

    assign hit = (avsAddress == ascs_pkg::STEP8_CFG_ADDR); // RULE_06
    assign req = avsRead || avsWrite;
    // One wait cycle, then the answer edge; a frozen clock holds the answer
    // back, since a write cannot land on an edge that sees clkEn low
    assign avsWaitrequest = req && !(ack_q && clkEn);
    assign doWrite = avsWrite && ack_q && hit;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else if (clkEn) begin
            ack_q <= req && !ack_q;
        end
    end

    // Unmapped words read zero and drop writes
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdData_q <= ascs_pkg::UNMAPPED_READ;
        end else if (clkEn && avsRead && !ack_q) begin
            rdData_q <= hit ? {16'h0000, cfgWord & ascs_pkg::WRITABLE_MASK}
                            : ascs_pkg::UNMAPPED_READ; // RULE_07
        end
    end
    assign avsReaddata = rdData_q;

    ascs_cfg_reg u_reg (
        .core_clk(core_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .wrEn(doWrite),
        .wrData(avsWritedata[15:0]),
        .wrBytes(avsByteenable[1:0]),
        .cfgWord(cfgWord)
    );

    assign stepEnable = cfgWord[ascs_pkg::EN_BIT]; // RULE_01
    assign stepGainSelect = cfgWord[ascs_pkg::GAIN_HI:ascs_pkg::GAIN_LO];
    assign stepGainFactor = gain_factor(stepGainSelect); // RULE_02
    assign stepNegativeInputSelect = cfgWord[ascs_pkg::NEG_BIT];
    assign stepPositiveInputSelect = cfgWord[ascs_pkg::POS_HI:ascs_pkg::POS_LO];
    assign stepPositiveInternal = stepPositiveInputSelect >= ascs_pkg::POS_FIRST_INTERNAL;
    assign stepExternalChannel = stepPositiveInputSelect[2:0]; // RULE_04

    always_comb begin
        if (stepPositiveInternal) begin
            stepNegativeRoute = ascs_pkg::ASCS_NEG_AUTO; // RULE_05
        end else if (stepNegativeInputSelect) begin
            stepNegativeRoute = ascs_pkg::ASCS_NEG_INPUT7; // RULE_03
        end else begin
            stepNegativeRoute = ascs_pkg::ASCS_NEG_GROUND; // RULE_03
        end
    end

    property p_reserved_zero;
        @(posedge core_clk) disable iff (!nrst)
            avsRead && !avsWaitrequest && hit |->
                avsReaddata[31:5] == {16'h0000, avsReaddata[15:13], 8'h00};
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // RULE_07

    property p_wait_one;
        @(posedge core_clk) disable iff (!nrst)
            clkEn && $rose(req) |-> avsWaitrequest ##1 (!clkEn || !avsWaitrequest);
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus answer timing wrong");

    property p_write_en;
        @(posedge core_clk) disable iff (!nrst)
            clkEn && doWrite && avsByteenable[1] |=> stepEnable == $past(avsWritedata[15]);
    endproperty
    a_write_en: assert property (p_write_en) else $error("enable bit not written"); // RULE_01

    property p_gain;
        @(posedge core_clk) disable iff (!nrst)
            stepGainSelect[1] |-> stepGainFactor == 3'h4;
    endproperty
    a_gain: assert property (p_gain) else $error("gain factor wrong"); // RULE_02

    property p_auto_neg;
        @(posedge core_clk) disable iff (!nrst)
            stepPositiveInputSelect[3] |-> stepNegativeRoute == ascs_pkg::ASCS_NEG_AUTO;
    endproperty
    a_auto_neg: assert property (p_auto_neg) else $error("negative not automatic"); // RULE_05

    property p_ext_neg;
        @(posedge core_clk) disable iff (!nrst)
            !stepPositiveInputSelect[3] |-> stepNegativeRoute == {1'b0, stepNegativeInputSelect};
    endproperty
    a_ext_neg: assert property (p_ext_neg) else $error("negative select wrong"); // RULE_03

    property p_ext_chan;
        @(posedge core_clk) disable iff (!nrst)
            !stepPositiveInternal |-> {1'b0, stepExternalChannel} == stepPositiveInputSelect;
    endproperty
    a_ext_chan: assert property (p_ext_chan) else $error("external channel wrong"); // RULE_04

    property p_reset_val;
        @(posedge core_clk) $rose(nrst) |-> cfgWord == 16'h0008;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("reset value wrong"); // RULE_06

    // Answer edge of a mapped access, as the master sees it
    sequence s_answer_write;
        avsWrite && hit && !avsWaitrequest;
    endsequence

    sequence s_answer_read;
        avsRead && hit && !avsWaitrequest;
    endsequence

    // Keyed on the bus answer, not on clkEn, so a frozen edge cannot hide a lost write
    property p_wr_lands;
        @(posedge core_clk) disable iff (!nrst)
            s_answer_write ##0 avsByteenable[1] |=>
                stepEnable == $past(avsWritedata[15]);
    endproperty
    a_wr_lands: assert property (p_wr_lands) else $error("answered write lost"); // RULE_01

    property p_wr_gain;
        @(posedge core_clk) disable iff (!nrst)
            s_answer_write ##0 avsByteenable[1] |=>
                stepGainSelect == $past(avsWritedata[14:13]);
    endproperty
    a_wr_gain: assert property (p_wr_gain) else $error("gain not written"); // RULE_02

    property p_wr_neg;
        @(posedge core_clk) disable iff (!nrst)
            s_answer_write ##0 avsByteenable[0] |=>
                stepNegativeInputSelect == $past(avsWritedata[4]);
    endproperty
    a_wr_neg: assert property (p_wr_neg) else $error("negative bit not written"); // RULE_03

    property p_wr_pos;
        @(posedge core_clk) disable iff (!nrst)
            s_answer_write ##0 avsByteenable[0] |=>
                stepPositiveInputSelect == $past(avsWritedata[3:0]);
    endproperty
    a_wr_pos: assert property (p_wr_pos) else $error("positive code not written"); // RULE_04

    // Each byte lane guards its own half of the word
    property p_keep_high;
        @(posedge core_clk) disable iff (!nrst)
            s_answer_write ##0 !avsByteenable[1] |=> $stable(cfgWord[15:8]);
    endproperty
    a_keep_high: assert property (p_keep_high) else $error("upper byte changed");

    property p_keep_low;
        @(posedge core_clk) disable iff (!nrst)
            s_answer_write ##0 !avsByteenable[0] |=> $stable(cfgWord[7:0]);
    endproperty
    a_keep_low: assert property (p_keep_low) else $error("lower byte changed");

    property p_wr_drop;
        @(posedge core_clk) disable iff (!nrst)
            avsWrite && !hit && !avsWaitrequest |=> $stable(cfgWord);
    endproperty
    a_wr_drop: assert property (p_wr_drop) else $error("unmapped write landed");

    property p_rd_word;
        @(posedge core_clk) disable iff (!nrst)
            s_answer_read |->
                avsReaddata == {16'h0000, cfgWord & ascs_pkg::WRITABLE_MASK};
    endproperty
    a_rd_word: assert property (p_rd_word) else $error("read data wrong"); // RULE_06

    property p_rd_unmapped;
        @(posedge core_clk) disable iff (!nrst)
            avsRead && !hit && !avsWaitrequest |-> avsReaddata == 32'h00000000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_rsvd_stored;
        @(posedge core_clk) disable iff (!nrst)
            cfgWord[12:5] == 8'h00;
    endproperty
    a_rsvd_stored: assert property (p_rsvd_stored) else $error("reserved bits set"); // RULE_07

    property p_gain_low;
        @(posedge core_clk) disable iff (!nrst)
            !stepGainSelect[1] |->
                stepGainFactor == {1'b0, stepGainSelect[0], !stepGainSelect[0]};
    endproperty
    a_gain_low: assert property (p_gain_low) else $error("low gain factor wrong"); // RULE_02

    property p_internal;
        @(posedge core_clk) disable iff (!nrst)
            stepPositiveInternal == stepPositiveInputSelect[3];
    endproperty
    a_internal: assert property (p_internal) else $error("internal flag wrong"); // RULE_05

    // Clock enable low must hold every register, bus side included
    property p_frz_word;
        @(posedge core_clk) disable iff (!nrst)
            !clkEn |=> $stable(cfgWord);
    endproperty
    a_frz_word: assert property (p_frz_word) else $error("word moved while frozen");

    property p_frz_bus;
        @(posedge core_clk) disable iff (!nrst)
            !clkEn |=> $stable(avsReaddata) && $stable(ack_q);
    endproperty
    a_frz_bus: assert property (p_frz_bus) else $error("bus state moved while frozen");
endmodule : ascs_step_config

// ---- common/ascs_pkg.sv ----
package ascs_pkg;
    // Register map, byte addressed on the bus (bus address = index * 4)
    localparam logic [7:0] STEP8_CFG_IDX = 8'h98;
    localparam logic [9:0] STEP8_CFG_ADDR = 10'h260;
    localparam logic [15:0] STEP8_CFG_RESET = 16'h0008;
    // Field positions
    localparam int EN_BIT = 15;
    localparam int GAIN_HI = 14;
    localparam int GAIN_LO = 13;
    localparam int NEG_BIT = 4;
    localparam int POS_HI = 3;
    localparam int POS_LO = 0;
    localparam logic [15:0] WRITABLE_MASK = 16'he01f;
    // Bus answer timing: one wait cycle per access
    localparam int BUS_WAIT_CYCLES = 1;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

    typedef enum logic [1:0] {
        ASCS_GAIN_X1 = 2'h0,
        ASCS_GAIN_X2 = 2'h1,
        ASCS_GAIN_X4 = 2'h2
    } ascs_gain_t;

    typedef enum logic [1:0] {
        ASCS_NEG_GROUND = 2'h0,
        ASCS_NEG_INPUT7 = 2'h1,
        ASCS_NEG_AUTO = 2'h2
    } ascs_neg_t;

    localparam logic [3:0] POS_FIRST_INTERNAL = 4'h8;
endpackage : ascs_pkg

// ---- hdl/ascs_cfg_reg.sv ----
`timescale 1ns/1ps
// Holds the raw step word; only writable bits ever change
module ascs_cfg_reg (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // Write side
    input wire logic wrEn,
    input wire logic [15:0] wrData,
    input wire logic [1:0] wrBytes,
    // Stored word
    output logic [15:0] cfgWord
);
    logic [15:0] word_q;
    logic [15:0] laneMask;

    assign laneMask = {{8{wrBytes[1]}}, {8{wrBytes[0]}}} & ascs_pkg::WRITABLE_MASK;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            word_q <= ascs_pkg::STEP8_CFG_RESET; // RULE_06
        end else if (clkEn && wrEn) begin
            word_q <= (word_q & ~laneMask) | (wrData & laneMask); // RULE_07
        end
    end

    assign cfgWord = word_q;
endmodule : ascs_cfg_reg

// ---- bench/tb_ascs_step_config.sv ----
`timescale 1ns/1ps
module tb_ascs_step_config;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    logic [9:0] avsAddress = 10'h000;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h00000000;
    logic [3:0] avsByteenable = 4'h0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    wire [16:0] outs;
    logic [31:0] rd;
    logic [15:0] d;
    logic [1:0] be;
    logic [9:0] a;
    int m;
    int err_count = 0;
    int checked = 0;

    ascs_step_config i_ascs_step_config (.core_clk(core_clk), .nrst(nrst), .clkEn(clkEn),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .stepEnable(outs[16]), .stepGainSelect(outs[15:14]), .stepGainFactor(outs[13:11]),
        .stepNegativeInputSelect(outs[10]), .stepPositiveInputSelect(outs[9:6]),
        .stepPositiveInternal(outs[5]), .stepExternalChannel(outs[4:2]),
        .stepNegativeRoute(outs[1:0]));

    always #50 core_clk = ~core_clk;

    task automatic finish_test;
        $display("Mismatches %0d of %0d comparisons", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // Request held until waitrequest seen low; no latency assumed
    task automatic bus(input logic wr, input logic [9:0] ad, input logic [15:0] wd,
                       input logic [1:0] bl, output logic [31:0] rv);
        int n;
        n = 0;
        @(posedge core_clk);
        avsAddress <= ad;
        avsWritedata <= {16'h0000, wd};
        avsByteenable <= {2'h0, bl};
        avsWrite <= wr;
        avsRead <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            err_count++;
            $display("[ERR] %0t bus answer missing", $time);
            finish_test();
        end else begin
            rv = avsReaddata;
            avsWrite <= 1'b0;
            avsRead <= 1'b0;
        end
    endtask : bus

    function automatic logic [16:0] exp_out(input int v);
        logic [1:0] g;
        g = v[14:13];
        return {v[15], g, (g == 2'h0) ? 3'h1 : (g == 2'h1) ? 3'h2 : 3'h4, v[4], v[3:0],
                v[3], v[2:0], v[3] ? 2'h2 : {1'b0, v[4]}};
    endfunction : exp_out

    function automatic int lanes(input logic [1:0] bl);
        return (bl[0] ? 32'h000000ff : 32'h00000000) | (bl[1] ? 32'h0000ff00 : 32'h00000000);
    endfunction : lanes

    task automatic cmp_rd(input logic [31:0] got, input int v);
        checked++;
        if (got !== v[31:0]) begin
            err_count++;
            $display("[ERR] %0t readdata %h expected %h", $time, got, v);
        end
    endtask : cmp_rd

    task automatic cmp_out(input logic [16:0] ev);
        checked++;
        if (outs !== ev) begin
            err_count++;
            $display("[ERR] %0t step outputs %h expected %h", $time, outs, ev);
        end
    endtask : cmp_out

    task automatic check_all;
        bus(1'b0, 10'h260, 16'h0000, 2'h3, rd);
        cmp_rd(rd, m);
        cmp_out(exp_out(m));
    endtask : check_all

    initial begin
        void'($urandom(32'h2a5d));
        m = 32'h00000008;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        @(negedge core_clk);
        cmp_rd(avsReaddata, 0);
        check_all();
        // Last eight writes go to unmapped places and must leave the word alone
        for (int i = 0; i < 40; i++) begin
            a = (i < 32) ? 10'h260 : (i[0] ? 10'h264 : 10'h000);
            d = 16'($urandom);
            d[14:13] = 2'(i);
            d[4:0] = 5'(i);
            be = (i < 16) ? 2'h3 : 2'($urandom);
            bus(1'b1, a, d, be, rd);
            if (i < 32) m = (m & ~lanes(be)) | (d & lanes(be) & 32'h0000e01f);
            @(negedge core_clk);
            cmp_out(exp_out(m));
            bus(1'b0, a, 16'h0000, 2'h3, rd);
            cmp_rd(rd, (i < 32) ? m : 0);
        end
        // Enable dropped in the answer cycle: the write must wait, then land
        d = 16'h8015;
        m = 32'h00008015;
        fork
            bus(1'b1, 10'h260, d, 2'h3, rd);
            begin
                repeat (2) @(posedge core_clk);
                clkEn <= 1'b0;
                repeat (3) @(posedge core_clk);
                clkEn <= 1'b1;
            end
        join
        @(negedge core_clk);
        cmp_out(exp_out(m));
        check_all();
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        m = 32'h00000008;
        @(negedge core_clk);
        cmp_rd(avsReaddata, 0);
        check_all();
        finish_test();
    end
endmodule : tb_ascs_step_config
